/* design/dps_drive_state.v */
// Drive profile state machine with command word, state word and error code registers.
`timescale 1ns/1ps
`include "dps_consts.vh"
// Behaviour
// RULE1: Leave not-ready by itself after initialisation.
// RULE2: Successful fault reset enters switch-on-disabled.
// RULE3: Voltage off or no release disables switch-on.
// RULE4: Incomplete DC link charge forces switch-on-disabled.
// RULE5: Quick stop active leads to switch-on-disabled.
// RULE6: Voltage enable moves disabled to ready.
// RULE7: Switch-on cleared returns to ready.
// RULE8: Switch-on set moves ready to switched-on.
// RULE9: Operation enable cleared returns to switched-on.
// RULE10: Switched-on needs power unit voltage.
// RULE11: Operation enable starts mod-off pause, minimum wait.
// RULE12: Start functions complete before operation enabled.
// RULE13: Quick stop request enters quick stop active.
// RULE14: Error enters fault reaction, then fault.
// RULE15: Error code is read-only sixteen bits.
// RULE16: Internal error number maps to profile code.
// RULE17: Warnings alone report code zero.
// RULE18: Command word bits 0,1,2,3,7 control.
// RULE19: State word low bits encode state.
// RULE20: Controller commands via bits 0-3 and 7.
// RULE21: One state register, errors take priority.
module dps_drive_state #(
	parameter MIN_OFF_CYCLES = `DPS_MIN_OFF_CYCLES,
	parameter FAULT_REACT_CYCLES = `DPS_FAULT_REACT_CYCLES
) (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Register port.
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// Internal events from the same clock domain.
	input wire init_done,
	input wire [7:0] err_num,
	input wire err_active,
	input wire start_done,
	// Asynchronous status pins.
	input wire dc_link_charged,
	input wire control_release,
	input wire power_unit_ok,
	// State outputs.
	output reg [15:0] drive_state_word,
	output reg [15:0] drive_error_code,
	output reg [3:0] inverter_state_display,
	output reg start_request,
	output reg modulation_on
);
	localparam [3:0] ST_NOT_READY = 4'h0;
	localparam [3:0] ST_DISABLED = 4'h1;
	localparam [3:0] ST_READY = 4'h2;
	localparam [3:0] ST_SWITCHED_ON = 4'h3;
	localparam [3:0] ST_MOD_OFF = 4'h4;
	localparam [3:0] ST_START_OP = 4'h5;
	localparam [3:0] ST_OP_ENABLED = 4'h6;
	localparam [3:0] ST_QUICK_STOP = 4'h7;
	localparam [3:0] ST_FAULT_REACT = 4'h8;
	localparam [3:0] ST_FAULT = 4'h9;

	// Two-stage synchronisers for the pins.
	reg [2:0] sync1_q;
	reg [2:0] sync2_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {power_unit_ok, control_release, dc_link_charged};
			sync2_q <= sync1_q;
		end
	end
	wire dc_ok = sync2_q[0];
	wire release_ok = sync2_q[1];
	wire pu_ok = sync2_q[2];

	// Command word register.
	reg [15:0] cmd_q;
	reg fault_reset_d;
	reg fr_prev_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= `DPS_CW_RESET;
		end else if (reg_wr && reg_addr == `DPS_OFF_COMMAND_WORD) begin
			cmd_q <= reg_wdata; // [RULE18]
		end
	end
	wire cw_switch_on = cmd_q[`DPS_CW_SWITCH_ON]; // [RULE18] [RULE20]
	wire cw_voltage = cmd_q[`DPS_CW_ENABLE_VOLTAGE];
	wire cw_no_qs = cmd_q[`DPS_CW_NO_QUICK_STOP];
	wire cw_enable_op = cmd_q[`DPS_CW_ENABLE_OPERATION];
	wire cw_fault_reset = cmd_q[`DPS_CW_FAULT_RESET];

	// A fault reset acts on the rising edge of its bit, so a held bit cannot mask a new error.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fr_prev_q <= 1'b0;
		end else begin
			fr_prev_q <= cw_fault_reset;
		end
	end
	always @* begin
		fault_reset_d = cw_fault_reset && !fr_prev_q;
	end

	// Error code mapping.
	wire [15:0] mapped_code;
	dps_error_map u_map (
		.err_num(err_num),
		.err_code(mapped_code)
	);
	reg [15:0] err_code_d;
	always @* begin
		if (err_active) begin
			err_code_d = mapped_code; // [RULE16]
		end else begin
			err_code_d = `DPS_EC_NONE; // [RULE17]
		end
	end

	// Timer for mod-off pause and fault reaction.
	reg [31:0] tmr_q;
	reg [31:0] tmr_d;
	reg [3:0] state_q;
	reg [3:0] state_d;
	wire voltage_lost = !cw_voltage || !release_ok || !dc_ok;

	// Next-state logic; errors are evaluated before any command.
	always @* begin
		state_d = state_q;
		tmr_d = tmr_q;
		if (tmr_q != 32'h0) begin
			tmr_d = tmr_q - 32'h1;
		end
		if (err_active && state_q != ST_NOT_READY && state_q != ST_FAULT_REACT && state_q != ST_FAULT) begin
			state_d = ST_FAULT_REACT; // [RULE14] [RULE21]
			tmr_d = FAULT_REACT_CYCLES;
		end else begin
			case (state_q)
				ST_NOT_READY: begin
					if (init_done) begin
						state_d = ST_DISABLED; // [RULE1]
					end
				end
				ST_DISABLED: begin
					if (cw_voltage && cw_no_qs && release_ok && dc_ok && !cw_switch_on) begin
						state_d = ST_READY; // [RULE6] [RULE4]
					end
				end
				ST_READY: begin
					if (voltage_lost || !cw_no_qs) begin
						state_d = ST_DISABLED; // [RULE3] [RULE4]
					end else if (cw_switch_on && pu_ok) begin
						state_d = ST_SWITCHED_ON; // [RULE8] [RULE10]
					end
				end
				ST_SWITCHED_ON: begin
					if (voltage_lost || !cw_no_qs) begin
						state_d = ST_DISABLED; // [RULE3] [RULE4]
					end else if (!cw_switch_on) begin
						state_d = ST_READY; // [RULE7]
					end else if (cw_enable_op) begin
						state_d = ST_MOD_OFF; // [RULE11]
						tmr_d = MIN_OFF_CYCLES;
					end
				end
				ST_MOD_OFF, ST_START_OP: begin
					if (voltage_lost || !cw_no_qs) begin
						state_d = ST_DISABLED; // [RULE3]
					end else if (!cw_switch_on) begin
						state_d = ST_READY;
					end else if (!cw_enable_op) begin
						state_d = ST_SWITCHED_ON;
					end else if (state_q == ST_MOD_OFF && tmr_q <= 32'h1) begin
						state_d = ST_START_OP; // [RULE11]
					end else if (state_q == ST_START_OP && start_done) begin
						state_d = ST_OP_ENABLED; // [RULE12]
					end
				end
				ST_OP_ENABLED: begin
					if (voltage_lost) begin
						state_d = ST_DISABLED; // [RULE3] [RULE4]
					end else if (!cw_no_qs) begin
						state_d = ST_QUICK_STOP; // [RULE13]
					end else if (!cw_switch_on) begin
						state_d = ST_READY; // [RULE7]
					end else if (!cw_enable_op) begin
						state_d = ST_SWITCHED_ON; // [RULE9]
					end
				end
				ST_QUICK_STOP: begin
					state_d = ST_DISABLED; // [RULE5]
				end
				ST_FAULT_REACT: begin
					if (tmr_q <= 32'h1) begin
						state_d = ST_FAULT; // [RULE14]
					end
				end
				ST_FAULT: begin
					if (fault_reset_d && !err_active) begin
						state_d = ST_DISABLED; // [RULE2]
					end
				end
				default: begin
					state_d = ST_NOT_READY;
				end
			endcase
		end
	end

	// The single state register.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_NOT_READY;
			tmr_q <= 32'h0;
		end else begin
			state_q <= state_d; // [RULE21]
			tmr_q <= tmr_d;
		end
	end

	// State word encoding of the low bits.
	function [15:0] state_bits;
		input [3:0] st;
		input volt;
		begin
			case (st)
				ST_NOT_READY: state_bits = 16'h0000;
				ST_DISABLED: state_bits = 16'h0040;
				ST_READY: state_bits = 16'h0021;
				ST_SWITCHED_ON, ST_MOD_OFF, ST_START_OP: state_bits = 16'h0023;
				ST_OP_ENABLED: state_bits = 16'h0027;
				ST_QUICK_STOP: state_bits = 16'h0007;
				ST_FAULT_REACT: state_bits = 16'h000f;
				ST_FAULT: state_bits = 16'h0008;
				default: state_bits = 16'h0000;
			endcase
			state_bits = state_bits | {11'h000, volt, 4'h0};
		end
	endfunction

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_state_word <= 16'h0000;
			drive_error_code <= `DPS_EC_NONE;
			inverter_state_display <= 4'h0;
			start_request <= 1'b0;
			modulation_on <= 1'b0;
		end else begin
			drive_state_word <= state_bits(state_d, pu_ok); // [RULE19]
			drive_error_code <= err_code_d; // [RULE15]
			inverter_state_display <= state_d;
			start_request <= (state_d == ST_START_OP);
			modulation_on <= (state_d == ST_START_OP) || (state_d == ST_OP_ENABLED);
		end
	end

	// Read port; the error code is read-only and writes to it are ignored.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`DPS_OFF_ERROR_CODE: reg_rdata <= drive_error_code; // [RULE15]
				`DPS_OFF_COMMAND_WORD: reg_rdata <= cmd_q;
				`DPS_OFF_STATE_WORD: reg_rdata <= drive_state_word;
				`DPS_OFF_EVENT_CTRL: reg_rdata <= {12'h000, state_q};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule // dps_drive_state

/* design/dps_consts.vh */
// Offsets, field positions, reset values and timing counts of the drive state machine.
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH
`define DPS_OFF_ERROR_CODE 16'h603f
`define DPS_OFF_COMMAND_WORD 16'h6040
`define DPS_OFF_STATE_WORD 16'h6041
`define DPS_OFF_EVENT_CTRL 16'h7000
`define DPS_CW_SWITCH_ON 0
`define DPS_CW_ENABLE_VOLTAGE 1
`define DPS_CW_NO_QUICK_STOP 2
`define DPS_CW_ENABLE_OPERATION 3
`define DPS_CW_FAULT_RESET 7
`define DPS_CW_RESET 16'h0000
`define DPS_EC_NONE 16'h0000
`define DPS_EC_OVERVOLTAGE 16'h3210
`define DPS_EC_UNDERVOLTAGE 16'h3220
`define DPS_EC_GENERIC 16'h1000
`define DPS_EC_OVERCURRENT 16'h2300
`define DPS_EC_HEAT_INTERNAL 16'h4110
`define DPS_EC_HEAT_MODULE 16'h4210
`define DPS_EC_HEAT_DRIVE 16'h4310
`define DPS_EC_POWER_UNIT 16'h5400
`define DPS_EC_OVERLOAD 16'h3230
`define DPS_EC_BLOCKADE 16'h7121
`define DPS_MIN_OFF_TIME_US 1000
`define DPS_CLK_MHZ 125
`define DPS_MIN_OFF_CYCLES (`DPS_MIN_OFF_TIME_US * `DPS_CLK_MHZ)
`define DPS_FAULT_REACT_CYCLES 16
`endif

/* design/dps_error_map.v */
// Mapping of the internal error number to the profile error code.
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_error_map (
	// Internal error number, zero for none.
	input wire [7:0] err_num,
	// Profile error code.
	output reg [15:0] err_code
);
	always @* begin
		case (err_num)
			8'h01: err_code = `DPS_EC_OVERVOLTAGE; // [RULE16]
			8'h02: err_code = `DPS_EC_UNDERVOLTAGE; // [RULE16]
			8'h03, 8'h05, 8'h12, 8'h1e, 8'h1f, 8'h27, 8'h38, 8'h3a, 8'h83: err_code = `DPS_EC_GENERIC;
			8'h04: err_code = `DPS_EC_OVERCURRENT; // [RULE16]
			8'h06, 8'h07: err_code = `DPS_EC_HEAT_INTERNAL;
			8'h08, 8'h24: err_code = `DPS_EC_HEAT_MODULE;
			8'h09, 8'h0b: err_code = `DPS_EC_HEAT_DRIVE;
			8'h0c: err_code = `DPS_EC_POWER_UNIT;
			8'h10, 8'h11, 8'h13, 8'h14: err_code = `DPS_EC_OVERLOAD;
			8'h1a: err_code = `DPS_EC_BLOCKADE;
			default: err_code = `DPS_EC_NONE; // [RULE16] [RULE17]
		endcase
	end
endmodule // dps_error_map

/* verification/dps_drive_state_monitor.sv */
// Port checks of the drive state machine.
`timescale 1ns/1ps
module dps_drive_state_monitor (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Watched ports.
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire init_done,
	input wire err_active,
	input wire start_done,
	input wire [15:0] drive_state_word,
	input wire [15:0] drive_error_code,
	input wire [3:0] inverter_state_display,
	input wire start_request,
	input wire modulation_on
);
	wire [3:0] st = inverter_state_display;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_init; st == 4'h0 && init_done |-> ##[1:4] st == 4'h1; endproperty
	a_init: assert property (p_init) else $error("init stuck");
	property p_qs; st == 4'h7 |=> st == 4'h1; endproperty
	a_qs: assert property (p_qs) else $error("quick stop exit");
	property p_err; err_active && st != 4'h0 && st < 4'h8 |-> ##[1:3] st == 4'h8; endproperty
	a_err: assert property (p_err) else $error("error ignored");
	property p_fr; st == 4'h8 |-> ##[1:40] st == 4'h9; endproperty
	a_fr: assert property (p_fr) else $error("fault reaction stuck");
	// The pause lasts ten cycles in simulation, so eight must always be seen.
	property p_mo; $rose(st == 4'h4) |-> (st == 4'h4) [*8]; endproperty
	a_mo: assert property (p_mo) else $error("pause short");
	property p_st; st == 4'h5 && !start_done |=> st != 4'h6; endproperty
	a_st: assert property (p_st) else $error("start skipped");
	property p_sr; start_request == (st == 4'h5) && modulation_on == (st == 4'h5 || st == 4'h6); endproperty
	a_sr: assert property (p_sr) else $error("start outputs");
	property p_pw; st == 4'h3 |-> drive_state_word[4]; endproperty
	a_pw: assert property (p_pw) else $error("on without power");
	property p_sw; st == 4'h6 |-> (drive_state_word & 16'h006f) == 16'h0027; endproperty
	a_sw: assert property (p_sw) else $error("state word");
	property p_rd; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_rd: assert property (p_rd) else $error("stray read data");
	property p_ec; !err_active && !$past(err_active) |-> drive_error_code == 16'h0000; endproperty
	a_ec: assert property (p_ec) else $error("code without error");
endmodule // dps_drive_state_monitor

/* verification/dps_bus_master.sv */
// Bus master model that writes the command word and reads registers.
`timescale 1ns/1ps
module dps_bus_master (
	// Clock.
	input wire clk,
	// Register port.
	output reg [15:0] reg_addr,
	output reg [15:0] reg_wdata,
	output reg reg_wr,
	output reg reg_rd,
	input wire [15:0] reg_rdata
);
	initial begin
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Only bits 0 to 3 and 7 carry commands; data is inverted once released.
	task wr(input [15:0] a, input [15:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d & 16'h008f;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_wdata <= ~(d & 16'h008f);
		end
	endtask
	task rd(input [15:0] a, output [15:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			// The read data stand only until the next rising edge, so take them mid-cycle.
			@(negedge clk);
			d = reg_rdata;
		end
	endtask
endmodule // dps_bus_master

/* verification/dps_drive_state_tb.sv */
// Self-checking testbench of the drive state machine.
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_drive_state_tb;
	reg clk, rst_n, init_done, err_active, start_done, dc_link_charged, control_release, power_unit_ok;
	reg [7:0] err_num;
	reg [15:0] rv;
	wire [15:0] reg_addr, reg_wdata, reg_rdata, drive_state_word, drive_error_code;
	wire reg_wr, reg_rd, start_request, modulation_on;
	wire [3:0] inverter_state_display;
	integer err_total, n_compared;
	dps_drive_state #(.MIN_OFF_CYCLES(10), .FAULT_REACT_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.init_done(init_done), .err_num(err_num), .err_active(err_active), .start_done(start_done),
		.dc_link_charged(dc_link_charged), .control_release(control_release), .power_unit_ok(power_unit_ok),
		.drive_state_word(drive_state_word), .drive_error_code(drive_error_code),
		.inverter_state_display(inverter_state_display), .start_request(start_request), .modulation_on(modulation_on));
	dps_bus_master pm (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	task conclude;
		begin
			if (err_total == 0 && n_compared > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Waits a bounded time for the state, so a refusal shows as a mismatch.
	task wst(input [3:0] e);
		integer k;
		begin
			k = 0;
			while (inverter_state_display !== e && k < 300) begin
				@(negedge clk);
				k = k + 1;
			end
			chk({12'h000, inverter_state_display}, {12'h000, e});
		end
	endtask
	task cmd(input [15:0] d);
		pm.wr(`DPS_OFF_COMMAND_WORD, d);
	endtask
	task flt(input [7:0] n, input [15:0] code);
		begin
			cmd(16'h0006);
			wst(4'h2);
			err_num <= n;
			err_active <= 1'b1;
			wst(4'h9);
			pm.rd(`DPS_OFF_STATE_WORD, rv);
			chk(rv & 16'h004f, 16'h0008);
			pm.rd(`DPS_OFF_ERROR_CODE, rv);
			chk(rv, code);
			err_active <= 1'b0;
			cmd(16'h0080);
			wst(4'h1);
			cmd(16'h0000);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#400000;
		err_total = err_total + 1;
		conclude;
	end
	initial begin
		err_total = 0;
		n_compared = 0;
		rst_n = 1'b0;
		init_done = 1'b1;
		err_num = 8'h00;
		err_active = 1'b0;
		start_done = 1'b0;
		dc_link_charged = 1'b1;
		control_release = 1'b1;
		power_unit_ok = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wst(4'h1);
		pm.wr(`DPS_OFF_ERROR_CODE, 16'h0005);
		pm.rd(`DPS_OFF_ERROR_CODE, rv);
		chk(rv, 16'h0000);
		cmd(16'h0006);
		wst(4'h2);
		pm.rd(`DPS_OFF_STATE_WORD, rv);
		chk(rv & 16'h006f, 16'h0021);
		cmd(16'h0007);
		repeat (8) @(posedge clk);
		wst(4'h2);
		power_unit_ok <= 1'b1;
		cmd(16'h0006);
		cmd(16'h0007);
		wst(4'h3);
		cmd(16'h000f);
		wst(4'h5);
		chk({15'h0000, start_request}, 16'h0001);
		repeat (8) @(posedge clk);
		wst(4'h5);
		start_done <= 1'b1;
		wst(4'h6);
		chk({14'h0000, start_request, modulation_on}, 16'h0001);
		pm.rd(`DPS_OFF_EVENT_CTRL, rv);
		chk(rv, 16'h0006);
		pm.rd(`DPS_OFF_COMMAND_WORD, rv);
		chk(rv, 16'h000f);
		cmd(16'h0007);
		wst(4'h3);
		cmd(16'h000f);
		wst(4'h6);
		cmd(16'h000e);
		wst(4'h2);
		cmd(16'h0007);
		cmd(16'h000f);
		wst(4'h6);
		cmd(16'h000b);
		wst(4'h1);
		cmd(16'h0006);
		cmd(16'h0007);
		wst(4'h3);
		cmd(16'h0005);
		wst(4'h1);
		cmd(16'h0006);
		wst(4'h2);
		control_release <= 1'b0;
		wst(4'h1);
		control_release <= 1'b1;
		dc_link_charged <= 1'b0;
		cmd(16'h0000);
		cmd(16'h0006);
		repeat (8) @(posedge clk);
		wst(4'h1);
		dc_link_charged <= 1'b1;
		cmd(16'h0000);
		flt(8'h01, 16'h3210);
		flt(8'h02, 16'h3220);
		flt(8'h04, 16'h2300);
		flt(8'h18, 16'h0000);
		pm.rd(`DPS_OFF_ERROR_CODE, rv);
		chk(rv, 16'h0000);
		conclude;
	end
endmodule // dps_drive_state_tb
bind dps_drive_state dps_drive_state_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.init_done(init_done), .err_active(err_active), .start_done(start_done), .drive_state_word(drive_state_word),
	.drive_error_code(drive_error_code), .inverter_state_display(inverter_state_display),
	.start_request(start_request), .modulation_on(modulation_on));
